// File: hdl/adc_ctrl_regs.svh
// Constants of the converter control block: offsets, fields, timing.
// Assumes a 200 MHz clock and a 32-bit APB register bus.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
`define CTRL_ADDR      12'h000
`define STATUS_ADDR    12'h004
`define RESULT_ADDR    12'h008
`define CTRL_RESET     9'h000
`define CTRL_SER       0
`define CTRL_EXTCLK    1
`define CTRL_SYNCPOL   2
`define CTRL_PD        3
`define CTRL_LOWPWR    4
`define CTRL_FAST      5
`define CTRL_REFOFF    6
`define CTRL_BUFOFF    7
`define CLK_PERIOD_NS  5
`define ACQ_TIME_NS    250
`define CONV_TIME_NS   1000
`define SCLK_HALF_NS   20
`define ACQ_CYCLES  ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYCLES (`SCLK_HALF_NS / `CLK_PERIOD_NS)
`define RESULT_BITS    16
`endif

// File: hdl/adc_ctrl_pkg.sv
// Types of the converter control block.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_ctrl_pkg;
   typedef enum logic [0:0] {ST_ACQ, ST_CONV} conv_state_t;
endpackage : adc_ctrl_pkg

// File: hdl/adc_ctrl.sv
// Conversion sequencer, result read-out and APB control registers.
// Assumes pins are asynchronous to clk; sampleData comes from the core.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_ctrl
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        convert_start_n,
   input  wire logic        device_select_n,
   input  wire logic        read_strobe_n,
   input  wire logic        sclkIn,
   input  wire logic        read_mode_or_chain_in,
   input  wire logic [15:0] sampleData,
   output var  logic [15:0] dataPins,
   output var  logic [15:0] dataOe,
   output var  logic        busy,
   output var  logic        holdActive,
   output var  logic        reducedPower,
   output var  logic        refOn,
   output var  logic        refBufferOn
);
   localparam int ACQ_N  = `ACQ_CYCLES;
   localparam int CONV_N = `CONV_CYCLES;
   localparam int HALF_N = `SCLK_HALF_CYCLES;

   logic [4:0]  pinRaw;
   logic        pinMeta [5];
   logic        pinSync [5];
   logic        startPrev;
   logic        sclkPrev;
   logic [8:0]  ctrl;
   logic [15:0] result;
   logic [15:0] shiftReg;
   logic [4:0]  bitCnt;
   logic        reading;
   logic        haveResult;
   logic        incompleteFlag;
   logic        sclkOut;
   logic [7:0]  divCnt;
   logic [15:0] timer;
   adc_ctrl_pkg::conv_state_t state;
   logic [15:0] next_dataPins;
   logic [15:0] next_dataOe;

   assign pinRaw = {read_mode_or_chain_in, sclkIn, read_strobe_n,
                    device_select_n, convert_start_n};

   // Two-flop synchronisers for every pin input
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               // Idle levels: strobes high, link clock and mode low
               pinMeta[gi] <= 1'(gi < 3);
               pinSync[gi] <= 1'(gi < 3);
            end
            else
            begin
               pinMeta[gi] <= pinRaw[gi];
               pinSync[gi] <= pinMeta[gi];
            end
         end
      end
   endgenerate

   wire startN    = pinSync[0];
   wire selN      = pinSync[1];
   wire rdN       = pinSync[2];
   wire sclkS     = pinSync[3];
   wire readMode  = pinSync[4];
   wire serMode   = ctrl[`CTRL_SER];
   wire extClk    = ctrl[`CTRL_EXTCLK];
   wire outEn     = !selN && !rdN;
   wire startFall = startPrev && !startN;
   wire acqDone   = (timer >= 16'(ACQ_N));
   wire convDone  = (state == adc_ctrl_pkg::ST_CONV) &&
                    (timer == 16'(CONV_N - 1));
   wire lowPwrArm = ctrl[`CTRL_LOWPWR] && !ctrl[`CTRL_FAST] && acqDone
                    && !startN;
   wire startConv = (state == adc_ctrl_pkg::ST_ACQ) && !ctrl[`CTRL_PD] &&
                    (startFall || lowPwrArm);
   wire extEdge   = !selN && sclkS && !sclkPrev;
   wire intEdge   = reading && !extClk && sclkOut && divCnt == 8'(HALF_N - 1);
   wire shiftEdge = reading && (extClk ? extEdge : intEdge);
   wire readGo    = serMode && outEn && haveResult && !reading &&
                    (extClk || readMode || !busy);
   wire slaveLoss = serMode && extClk && reading && convDone;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         startPrev <= 1'b1;
         sclkPrev  <= 1'b0;
      end
      else
      begin
         startPrev <= startN;
         sclkPrev  <= sclkS;
      end
   end

   // Conversion sequencer
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= adc_ctrl_pkg::ST_ACQ;
         timer <= 16'h0000;
         busy  <= 1'b0;
      end
      else
      begin
         case (state)
            adc_ctrl_pkg::ST_ACQ:
            begin
               if (startConv)
               begin
                  state <= adc_ctrl_pkg::ST_CONV;
                  timer <= 16'h0000;
                  busy  <= 1'b1;
               end
               else if (!acqDone)
               begin
                  timer <= timer + 16'h0001;
               end
            end
            adc_ctrl_pkg::ST_CONV:
            begin
               // Start edges are not looked at here
               if (convDone)
               begin
                  state <= adc_ctrl_pkg::ST_ACQ;
                  timer <= 16'h0000;
                  busy  <= 1'b0;
               end
               else
               begin
                  timer <= timer + 16'h0001;
               end
            end
            default:
            begin
               state <= adc_ctrl_pkg::ST_ACQ;
               timer <= 16'h0000;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         holdActive   <= 1'b0;
         reducedPower <= 1'b0;
         refOn        <= 1'b1;
         refBufferOn  <= 1'b1;
      end
      else
      begin
         holdActive   <= startConv || (busy && !convDone);
         reducedPower <= ctrl[`CTRL_PD] &&
                         state == adc_ctrl_pkg::ST_ACQ;
         refOn        <= !ctrl[`CTRL_REFOFF];
         refBufferOn  <= !ctrl[`CTRL_BUFOFF];
      end
   end

   // Result latch and serial shifter
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         result     <= 16'h0000;
         shiftReg   <= 16'h0000;
         haveResult <= 1'b0;
         reading    <= 1'b0;
         bitCnt     <= 5'h00;
      end
      else if (convDone)
      begin
         result     <= sampleData;
         shiftReg   <= sampleData;
         haveResult <= 1'b1;
         reading    <= 1'b0;
         bitCnt     <= 5'h00;
      end
      else if (readGo)
      begin
         reading <= 1'b1;
         // An external edge that opens the frame already shifts
         if (extClk && extEdge)
         begin
            shiftReg <= {shiftReg[14:0], read_mode_or_chain_in_s()};
            bitCnt   <= 5'h01;
         end
         else
         begin
            bitCnt <= 5'h00;
         end
      end
      else if (shiftEdge)
      begin
         shiftReg <= {shiftReg[14:0], read_mode_or_chain_in_s()};
         bitCnt   <= bitCnt + 5'h01;
         if (bitCnt == 5'(`RESULT_BITS - 1))
         begin
            reading    <= 1'b0;
            haveResult <= 1'b0;
         end
      end
      else if (!outEn && !extClk)
      begin
         reading <= 1'b0;
      end
   end

   function automatic logic read_mode_or_chain_in_s();
      read_mode_or_chain_in_s = extClk && readMode;
   endfunction : read_mode_or_chain_in_s

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         incompleteFlag <= 1'b0;
      end
      else
      begin
         incompleteFlag <= slaveLoss;
      end
   end

   // Internal serial clock divider
   always_ff @(posedge clk)
   begin
      if (reset || !reading || extClk)
      begin
         divCnt  <= 8'h00;
         sclkOut <= 1'b0;
      end
      else if (divCnt == 8'(HALF_N - 1))
      begin
         divCnt  <= 8'h00;
         sclkOut <= !sclkOut;
      end
      else
      begin
         divCnt <= divCnt + 8'h01;
      end
   end

   // Pin sharing between parallel bus and serial port
   always_comb
   begin
      next_dataPins = 16'h0000;
      next_dataOe   = 16'h0000;
      if (!serMode)
      begin
         next_dataPins = result;
         next_dataOe   = {16{outEn}};
      end
      else
      begin
         next_dataPins[8]  = shiftReg[15];
         next_dataOe[8]    = outEn;
         next_dataPins[9]  = sclkOut;
         next_dataOe[9]    = !extClk;
         next_dataPins[10] = ctrl[`CTRL_SYNCPOL] ^ reading;
         next_dataOe[10]   = !extClk;
         next_dataPins[11] = incompleteFlag;
         next_dataOe[11]   = extClk;
         next_dataPins[15:12] = result[15:12];
         next_dataOe[15:12]   = {4{outEn}};
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dataPins <= 16'h0000;
         dataOe   <= 16'h0000;
      end
      else
      begin
         dataPins <= next_dataPins;
         dataOe   <= next_dataOe;
      end
   end

   // APB slave, one wait state
   wire apbAcc = psel && penable && !pready;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         ctrl    <= `CTRL_RESET;
      end
      else
      begin
         pready  <= apbAcc;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (apbAcc)
         begin
            case (paddr)
               `CTRL_ADDR:
               begin
                  if (pwrite)
                     ctrl <= pwdata[8:0];
                  prdata <= {23'h00_0000, ctrl};
               end
               `STATUS_ADDR:
                  prdata <= {28'h000_0000, reducedPower, incompleteFlag,
                             haveResult, busy};
               `RESULT_ADDR:
                  prdata <= {16'h0000, result};
               default:
                  pslverr <= 1'b1;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_busy_rise: assert property (startConv |=> busy)
      else $error("busy did not rise at start");
   a_busy_len: assert property ($rose(busy) |-> busy [*8])
      else $error("busy fell too early");
   a_start_ignored: assert property (busy && startFall && !convDone
      |=> state == adc_ctrl_pkg::ST_CONV && $stable(timer) == 1'b0)
      else $error("start edge disturbed conversion");
   a_pd_block: assert property (ctrl[`CTRL_PD] && !busy |=> !busy)
      else $error("conversion started in power down");
   a_oe_gate: assert property (|dataOe[8] |-> $past(outEn))
      else $error("serial output enabled without select");
   a_par_bit11: assert property (!serMode && $stable(serMode)
      |=> dataPins[11] == $past(result[11]))
      else $error("bit 11 wrong in parallel mode");
   a_loss_pulse: assert property (slaveLoss |=> incompleteFlag
      ##1 !incompleteFlag || slaveLoss)
      else $error("incomplete read flag not pulsed");
   a_sync_pol: assert property (serMode && !extClk
      |=> dataPins[10] == ($past(ctrl[`CTRL_SYNCPOL]) ^ $past(reading)))
      else $error("frame strobe level wrong");
   a_lowpwr_start: assert property (state == adc_ctrl_pkg::ST_ACQ
      && lowPwrArm && !ctrl[`CTRL_PD] |=> busy)
      else $error("low power start missed");
   a_ref_follow: assert property
      (##1 refOn == !$past(ctrl[`CTRL_REFOFF]))
      else $error("reference enable wrong");

   c_conv: cover property ($fell(busy));
   c_serial_read: cover property (reading && bitCnt == 5'h0F && shiftEdge);
   c_loss: cover property (incompleteFlag);
   c_apb_err: cover property (pslverr);
endmodule : adc_ctrl
`default_nettype wire

// File: test/host_model.sv
// Host controller model: drives the start, select and read pins.
// Assumes a 200 MHz clk; the link clock runs only while clkRun is high.
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   input  wire logic clk,
   input  wire logic startLow,
   input  wire logic selLow,
   input  wire logic rdLow,
   input  wire logic clkRun,
   input  wire logic busy,
   output var  logic convert_start_n,
   output var  logic device_select_n,
   output var  logic read_strobe_n,
   output var  logic sclkIn,
   output var  logic dataReady
);
   logic busyQ = 1'b0;
   assign convert_start_n = !startLow;
   assign device_select_n = !selLow;
   assign read_strobe_n = !rdLow;
   // Link clock stands low outside frames, off the clk edges
   initial
   begin
      sclkIn = 1'b0;
      #1.2;
      forever #62.5 sclkIn = clkRun ? !sclkIn : 1'b0;
   end
   // Busy falling edge taken as data ready
   always_ff @(posedge clk) busyQ <= busy;
   assign dataReady = busyQ & !busy;
endmodule : host_model
`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the converter control block.
// Assumes APB answers after one wait cycle and pins sync in 2 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module tb;
   typedef struct {logic [7:0] ctrl; logic [2:0] outs;} row_t;
   row_t        rows [5] = '{'{8'h00, 3'h6}, '{8'h40, 3'h2},
                   '{8'h80, 3'h4}, '{8'hC0, 3'h0}, '{8'h08, 3'h7}};
   logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, startLow = 1'b0, selLow = 1'b0;
   logic        rdLow = 1'b0, clkRun = 1'b0, read_mode_or_chain_in = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [15:0] sampleData = 16'h0000, dataPins, dataOe, word;
   logic        pready, pslverr, busy, holdActive, reducedPower, refOn;
   logic        refBufferOn, convert_start_n, device_select_n;
   logic        read_strobe_n, sclkIn, dataReady, er;
   int          errors = 0, checksDone = 0, busyRun = 0, lastLen = 0;
   int          flagCount = 0;

   adc_ctrl adc_ctrl_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .convert_start_n,
      .device_select_n, .read_strobe_n, .sclkIn, .read_mode_or_chain_in,
      .sampleData, .dataPins, .dataOe, .busy, .holdActive, .reducedPower,
      .refOn, .refBufferOn);
   host_model host_model_inst (.clk, .startLow, .selLow, .rdLow, .clkRun,
      .busy, .convert_start_n, .device_select_n, .read_strobe_n, .sclkIn,
      .dataReady);

   always #2.5 clk = !clk;
   // Busy length and incomplete-read pulses
   always @(posedge clk)
   begin
      busyRun <= (busy === 1'b1) ? busyRun + 1 : 0;
      if (busy !== 1'b1 && busyRun != 0) lastLen <= busyRun;
      if (dataOe[11] === 1'b1 && dataPins[11] === 1'b1) flagCount++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      if (errors == 0 && checksDone > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(16'(n < 50), 16'h0001);
   endtask : apb

   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      for (n = 0; n < lim && busy !== lvl; n++) @(posedge clk);
      check(16'(n < lim), 16'h0001);
   endtask : wait_busy

   task automatic conv(input logic [15:0] val, input logic pdMid);
      int n;
      sampleData <= val;
      startLow <= 1'b1;
      wait_busy(1'b1, 20);
      check(16'(holdActive), 16'h0001);
      startLow <= 1'b0;
      if (pdMid)
         apb(1'b1, `CTRL_ADDR, 32'h0000_0008);
      else
      begin
         // Second start edge while busy
         repeat (20) @(posedge clk);
         startLow <= 1'b1;
         repeat (8) @(posedge clk);
         startLow <= 1'b0;
      end
      for (n = 0; n < 400 && dataReady !== 1'b1; n++) @(posedge clk);
      @(posedge clk);
      check(16'(busy), 16'h0000);
      check(16'(lastLen >= `CONV_CYCLES - 1 && lastLen <= `CONV_CYCLES + 1),
         16'h0001);
      repeat (12) @(posedge clk);
      check(16'(busy), 16'h0000);
   endtask : conv

   task automatic sread(input logic [15:0] exp, input logic pol, ext);
      logic       prevClk, prevSdo, nowClk;
      logic [1:0] prevFs;
      int         got, n;
      selLow <= 1'b1;
      rdLow <= 1'b1;
      clkRun <= ext;
      got = 0;
      prevClk = 1'b1;
      prevSdo = 1'b0;
      prevFs = 2'h0;
      for (n = 0; n < 3000 && got < 16; n++)
      begin
         @(posedge clk);
         nowClk = ext ? sclkIn : dataPins[9];
         if (nowClk === 1'b1 && prevClk === 1'b0)
         begin
            word = {word[14:0], prevSdo};
            got++;
            if (!ext) check(16'(prevFs), 16'({1'b1, !pol}));
         end
         prevClk = nowClk;
         prevSdo = dataPins[8];
         prevFs = {dataOe[10], dataPins[10]};
      end
      check(word, exp);
      selLow <= 1'b0;
      rdLow <= 1'b0;
      clkRun <= 1'b0;
   endtask : sread

   initial
   begin
      #200_000;
      errors++;
      close_out();
   end

   initial
   begin
      repeat (20) @(posedge clk);
      check(16'({busy, refOn, refBufferOn, pready, reducedPower}),
         16'h000C);
      check(dataOe, 16'h0000);
      reset <= 1'b0;
      apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
      check(rd[15:0], 16'(`CTRL_RESET));
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      check(16'(er), 16'h0001);
      foreach (rows[i])
      begin
         apb(1'b1, `CTRL_ADDR, {24'h00_0000, rows[i].ctrl});
         apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
         check(rd[15:0], {8'h00, rows[i].ctrl});
         repeat (4) @(posedge clk);
         check(16'({refOn, refBufferOn, reducedPower}),
            16'(rows[i].outs));
      end
      startLow <= 1'b1;
      repeat (12) @(posedge clk);
      check(16'(busy), 16'h0000);
      startLow <= 1'b0;
      apb(1'b1, `CTRL_ADDR, 32'h0000_0000);
      conv(16'h5A3C, 1'b0);
      apb(1'b0, `RESULT_ADDR, 32'h0000_0000);
      check(rd[15:0], 16'h5A3C);
      apb(1'b0, `STATUS_ADDR, 32'h0000_0000);
      check(rd[15:0], 16'h0002);
      selLow <= 1'b1;
      repeat (6) @(posedge clk);
      check(dataOe, 16'h0000);
      rdLow <= 1'b1;
      repeat (6) @(posedge clk);
      check(dataOe, 16'hFFFF);
      check(dataPins, 16'h5A3C);
      selLow <= 1'b0;
      rdLow <= 1'b0;
      for (int p = 0; p < 2; p++)
      begin
         apb(1'b1, `CTRL_ADDR, 32'(1 + 4 * p));
         conv(16'hC3A5 ^ 16'(p), 1'b0);
         sread(16'hC3A5 ^ 16'(p), p[0], 1'b0);
      end
      apb(1'b1, `CTRL_ADDR, 32'h0000_0003);
      conv(16'h9E61, 1'b0);
      // Link edges while deselected
      clkRun <= 1'b1;
      repeat (400) @(posedge clk);
      clkRun <= 1'b0;
      repeat (40) @(posedge clk);
      sread(16'h9E61, 1'b0, 1'b1);
      flagCount = 0;
      conv(16'h0F0F, 1'b0);
      check(16'(flagCount), 16'h0000);
      selLow <= 1'b1;
      rdLow <= 1'b1;
      clkRun <= 1'b1;
      repeat (60) @(posedge clk);
      conv(16'h1234, 1'b0);
      check(16'(flagCount), 16'h0001);
      selLow <= 1'b0;
      rdLow <= 1'b0;
      clkRun <= 1'b0;
      apb(1'b1, `CTRL_ADDR, 32'h0000_0010);
      startLow <= 1'b1;
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 400);
      wait_busy(1'b1, `ACQ_CYCLES + 10);
      startLow <= 1'b0;
      wait_busy(1'b0, 400);
      apb(1'b1, `CTRL_ADDR, 32'h0000_0000);
      startLow <= 1'b1;
      wait_busy(1'b1, 20);
      repeat (30) @(posedge clk);
      reset <= 1'b1;
      startLow <= 1'b0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check(16'({busy, holdActive}), 16'h0000);
      conv(16'hBEEF, 1'b0);
      conv(16'h7E81, 1'b1);
      check(16'(reducedPower), 16'h0001);
      close_out();
   end
endmodule : tb
`default_nettype wire
